// [shared/spc_pkg.sv]
// Shared constants, field layout and helpers of the sensor command engine
package spc_pkg;
  // Clock and timing
  localparam int CLK_MHZ       = 40;
  localparam int CONV_BASE_US  = 1;
  localparam int CONV_BASE_CYC = CONV_BASE_US * CLK_MHZ;
  localparam int ACK_NS        = 100;
  localparam int ACK_CYC       = (ACK_NS * CLK_MHZ + 999) / 1000;
  localparam int ACK_W         = 4;
  localparam int CNT_W         = 20;

  // Widths
  localparam int RES_W   = 24;
  localparam int LIM_W   = 16;
  localparam int CFG_W   = 11;
  localparam int FLAG_W  = 8;
  localparam int COEF_W  = 16;
  localparam int COEF_AW = 4;
  localparam int COEF_N  = 16;
  localparam int DATA_W  = 16;
  localparam int RD_W    = 48;

  // Command byte layout
  localparam logic [3:0] OP_SYS     = 4'h1;
  localparam logic [3:0] OP_CFG     = 4'h2;
  localparam logic [3:0] OP_LIM     = 4'h3;
  localparam logic [3:0] OP_CONV    = 4'h4;
  localparam logic [3:0] OP_RADC    = 4'h5;
  localparam logic [2:0] OP_RREG    = 3'h7;
  localparam logic [2:0] SYS_WMASK  = 3'h4;
  localparam logic [2:0] SYS_RMASK  = 3'h5;
  localparam logic [2:0] SYS_WFLAG  = 3'h6;
  localparam logic [2:0] SYS_RFLAG  = 3'h7;
  localparam int         CMD_RD_BIT = 3;
  localparam int         CMD_T_BIT  = 3;
  localparam int         CMD_P_BIT  = 2;
  localparam int         CMD_A1_BIT = 2;
  localparam int         CMD_A0_BIT = 1;

  // Interrupt flag positions, sent MSB first
  localparam int FLG_CRC            = 7;
  localparam int FLG_PHIGH          = 6;
  localparam int FLG_PLOW           = 5;
  localparam int FLG_THIGH          = 4;
  localparam int FLG_TLOW           = 3;
  localparam int FLG_FIFO_FULL      = 2;
  localparam int FLG_FIFO_THRESHOLD = 1;
  localparam int FLG_DONE           = 0;

  // Config word fields
  localparam int CFG_OSR_LSB = 0;
  localparam int CFG_RES_LSB = 3;
  localparam int CFG_FLT_LSB = 5;
  localparam int CFG_RAT_LSB = 8;
  localparam int MEAS_T      = 0;
  localparam int MEAS_P      = 1;

  // Reset values
  localparam logic [FLAG_W-1:0] MASK_RST   = 8'h00;
  localparam logic [FLAG_W-1:0] FLAG_RST   = 8'h00;
  localparam logic [CFG_W-1:0]  CFG_RST    = 11'h000;
  localparam logic [LIM_W-1:0]  LIM_LO_RST = 16'h0000;
  localparam logic [LIM_W-1:0]  LIM_HI_RST = 16'hFFFF;
  localparam logic [RES_W-1:0]  RES_RST    = 24'hFFFFFF;

  // Result bits shifted out per resolution code
  function automatic logic [4:0] resBits(input logic [1:0] res);
    unique case (res)
      2'h0: resBits = 5'd16;
      2'h1: resBits = 5'd18;
      2'h2: resBits = 5'd20;
      2'h3: resBits = 5'd24;
    endcase
  endfunction : resBits

  // Payload bits the host writes after a command byte
  function automatic logic [4:0] payloadBits(input logic [7:0] cmd);
    payloadBits = 5'd0;
    if (cmd[7:4] == OP_SYS && (cmd[3:1] == SYS_WMASK || cmd[3:1] == SYS_WFLAG))
      payloadBits = 5'd8;
    if ((cmd[7:4] == OP_CFG || cmd[7:4] == OP_LIM) && !cmd[CMD_RD_BIT])
      payloadBits = 5'd16;
  endfunction : payloadBits
endpackage : spc_pkg

// [hw/spc_spi_port.sv]
// Serial link front end running on the host's serial clock
module spc_spi_port (
  input  wire logic                       scl,
  input  wire logic                       csbN,
  input  wire logic                       nrst,
  input  wire logic                       sdi,
  input  wire logic [spc_pkg::FLAG_W-1:0] flags,
  input  wire logic [spc_pkg::FLAG_W-1:0] mask,
  input  wire logic [spc_pkg::CFG_W-1:0]  cfg [2],
  input  wire logic [spc_pkg::LIM_W-1:0]  lim [4],
  input  wire logic [spc_pkg::RES_W-1:0]  resT,
  input  wire logic [spc_pkg::RES_W-1:0]  resP,
  input  wire logic [spc_pkg::COEF_W-1:0] coefWord,
  output logic [7:0]                      cmdOut,
  output logic [spc_pkg::DATA_W-1:0]      dataOut,
  output logic                            cmdTgl,
  output logic [spc_pkg::COEF_AW-1:0]     coefAddr,
  output logic                            rdActive,
  output logic                            rdBit
);
  import spc_pkg::*;

  logic              frmRstN;
  logic [5:0]        bitCnt_q;
  logic [DATA_W-1:0] sh_q;
  logic [7:0]        cmd_q;
  logic [7:0]        cmdNow;
  logic [5:0]        lastBit;
  logic [RD_W-1:0]   rdWord;
  logic [RD_W-1:0]   outSh_q;

  // Read commands that shift data out after the command byte
  function automatic logic isRead(input logic [7:0] c);
    isRead = (c[7:4] == OP_SYS && (c[3:1] == SYS_RMASK || c[3:1] == SYS_RFLAG))
      || ((c[7:4] == OP_CFG || c[7:4] == OP_LIM) && c[CMD_RD_BIT])
      || c[7:4] == OP_RADC || c[7:5] == OP_RREG;
  endfunction : isRead

  // Top n bits of a result, left aligned in the read word
  function automatic logic [RD_W-1:0] alignRes(input logic [RES_W-1:0] v,
                                               input logic [4:0] n);
    alignRes = {v, {RES_W{1'b0}}} & ~({RD_W{1'b1}} >> n);
  endfunction : alignRes

  // Frame logic is cleared whenever chip select is high
  assign frmRstN = nrst & ~csbN;
  assign cmdNow  = {sh_q[6:0], sdi};
  assign lastBit = 6'(7 + payloadBits(cmd_q));
  assign coefAddr = cmd_q[4:1];

  // Bit counter, input shifter and command byte capture
  always_ff @(posedge scl or negedge frmRstN)
  begin
    if (!frmRstN)
    begin
      bitCnt_q <= '0;
      sh_q     <= '0;
      cmd_q    <= '0;
      rdActive <= 1'b0;
    end
    else
    begin
      if (bitCnt_q != 6'h3F)
        bitCnt_q <= bitCnt_q + 6'd1;
      sh_q <= {sh_q[DATA_W-2:0], sdi};
      if (bitCnt_q == 6'd7)
      begin
        cmd_q    <= cmdNow;
        rdActive <= isRead(cmdNow);
      end
    end
  end

  // Completed command handed to the core by a toggle, held until next one
  always_ff @(posedge scl or negedge nrst)
  begin
    if (!nrst)
    begin
      cmdOut  <= '0;
      dataOut <= '0;
      cmdTgl  <= 1'b0;
    end
    else if (bitCnt_q == 6'd7 && payloadBits(cmdNow) == 5'd0)
    begin
      cmdOut <= cmdNow;
      cmdTgl <= ~cmdTgl;
    end
    else if (bitCnt_q > 6'd7 && bitCnt_q == lastBit)
    begin
      cmdOut  <= cmd_q;
      dataOut <= {sh_q[DATA_W-2:0], sdi};
      cmdTgl  <= ~cmdTgl;
    end
  end

  // Read word chosen by the command byte
  always_comb
  begin
    rdWord = '0;
    if (cmd_q[7:4] == OP_SYS && cmd_q[3:1] == SYS_RMASK)
      rdWord[RD_W-1 -: FLAG_W] = mask;
    else if (cmd_q[7:4] == OP_SYS && cmd_q[3:1] == SYS_RFLAG)
      rdWord[RD_W-1 -: FLAG_W] = flags;
    else if (cmd_q[7:4] == OP_CFG)
      rdWord[RD_W-1 -: DATA_W] = DATA_W'(cfg[cmd_q[CMD_A0_BIT]]);
    else if (cmd_q[7:4] == OP_LIM)
      rdWord[RD_W-1 -: DATA_W] = lim[cmd_q[CMD_A1_BIT:CMD_A0_BIT]];
    else if (cmd_q[7:4] == OP_RADC)
    begin
      // Temperature first, then pressure, each cut to its resolution
      if (cmd_q[CMD_T_BIT] && cmd_q[CMD_P_BIT])
        rdWord = alignRes(resT, resBits(cfg[MEAS_T][CFG_RES_LSB +: 2]))
          | (alignRes(resP, resBits(cfg[MEAS_P][CFG_RES_LSB +: 2]))
             >> resBits(cfg[MEAS_T][CFG_RES_LSB +: 2]));
      else if (cmd_q[CMD_T_BIT])
        rdWord = alignRes(resT, resBits(cfg[MEAS_T][CFG_RES_LSB +: 2]));
      else if (cmd_q[CMD_P_BIT])
        rdWord = alignRes(resP, resBits(cfg[MEAS_P][CFG_RES_LSB +: 2]));
    end
    else if (cmd_q[7:5] == OP_RREG)
      rdWord[RD_W-1 -: COEF_W] = coefWord;
  end

  // Output shifter changes on the falling edge; chip select high stops it
  always_ff @(negedge scl or negedge frmRstN)
  begin
    if (!frmRstN)
      outSh_q <= '0;
    else if (bitCnt_q == 6'd8)
      outSh_q <= rdWord;
    else if (bitCnt_q > 6'd8)
      outSh_q <= {outSh_q[RD_W-2:0], 1'b0};
  end

  assign rdBit = outSh_q[RD_W-1];
endmodule : spc_spi_port

// [hw/spc_engine.sv]
// Sensor command engine: link, register set and conversion sequencer

module spc_engine #(
  parameter int CONV_BASE_CYCLES = spc_pkg::CONV_BASE_CYC
) (
  input  wire logic                        mclk,
  input  wire logic                        nrst,
  input  wire logic                        scl,
  input  wire logic                        csbN,
  input  wire logic                        sdi,
  output logic                             sdo,
  output logic                             irq,
  input  wire logic [spc_pkg::RES_W-1:0]   adcTemp,
  input  wire logic [spc_pkg::RES_W-1:0]   adcPress,
  input  wire logic                        nvmWe,
  input  wire logic [spc_pkg::COEF_AW-1:0] nvmAddr,
  input  wire logic [spc_pkg::COEF_W-1:0]  nvmData
);
  import spc_pkg::*;

  typedef enum logic [1:0] {CONV_IDLE, CONV_TEMP, CONV_PRES} spcConv_t;

  // Link side handover
  logic [7:0]         linkCmd;
  logic [DATA_W-1:0]  linkData;
  logic               linkTgl;
  logic [COEF_AW-1:0] coefAddr;
  logic [COEF_W-1:0]  coefWord;
  logic               rdActive;
  logic               rdBit;

  // Crossing stages
  logic csbS1_q;
  logic csbS2_q;
  logic tglS1_q;
  logic tglS2_q;
  logic tglS3_q;
  logic cmdEv;

  // Decode
  logic isSys;
  logic isWMask;
  logic isWFlag;
  logic isWCfg;
  logic isWLim;
  logic isConv;
  logic isKnown;
  logic busy;
  logic accept;
  logic limitSelectHi;
  logic limitSelectLo;

  // Register set
  logic [FLAG_W-1:0] mask_q;
  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flagSet;
  logic [FLAG_W-1:0] flagClr;
  logic [CFG_W-1:0]  cfg_q [2];
  logic [LIM_W-1:0]  lim_q [4];
  logic [RES_W-1:0]  resT_q;
  logic [RES_W-1:0]  resP_q;
  logic [COEF_W-1:0] coefMem [COEF_N];

  // Sequencer
  spcConv_t          state_q;
  logic [CNT_W-1:0]  convCnt_q;
  logic              wantP_q;
  logic              tDone;
  logic              pDone;
  logic              convEnd;
  logic [ACK_W-1:0]  ackCnt_q;

  // Frozen copies read by the link during a frame
  logic [FLAG_W-1:0] snapFlags_q;
  logic [FLAG_W-1:0] snapMask_q;
  logic [CFG_W-1:0]  snapCfg_q [2];
  logic [LIM_W-1:0]  snapLim_q [4];
  logic [RES_W-1:0]  snapResT_q;
  logic [RES_W-1:0]  snapResP_q;

  // Conversion length for an oversampling code
  function automatic logic [CNT_W-1:0] convCycles(input logic [2:0] osr);
    convCycles = CNT_W'(CONV_BASE_CYCLES) << osr;
  endfunction : convCycles

  // Limit check on the top 16 result bits: {above high, below low}
  function automatic logic [1:0] limFlags(input logic [RES_W-1:0] v,
                                          input logic [LIM_W-1:0] lo,
                                          input logic [LIM_W-1:0] hi);
    limFlags = {v[RES_W-1 -: LIM_W] > hi, v[RES_W-1 -: LIM_W] < lo};
  endfunction : limFlags

  // Serial clock domain front end
  spc_spi_port uPort (
    .scl      (scl),
    .csbN     (csbN),
    .nrst     (nrst),
    .sdi      (sdi),
    .flags    (snapFlags_q),
    .mask     (snapMask_q),
    .cfg      (snapCfg_q),
    .lim      (snapLim_q),
    .resT     (snapResT_q),
    .resP     (snapResP_q),
    .coefWord (coefWord),
    .cmdOut   (linkCmd),
    .dataOut  (linkData),
    .cmdTgl   (linkTgl),
    .coefAddr (coefAddr),
    .rdActive (rdActive),
    .rdBit    (rdBit)
  );

  // Chip select and command toggle synchronisers
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      csbS1_q <= 1'b1;
      csbS2_q <= 1'b1;
      tglS1_q <= 1'b0;
      tglS2_q <= 1'b0;
      tglS3_q <= 1'b0;
    end
    else
    begin
      csbS1_q <= csbN;
      csbS2_q <= csbS1_q;
      tglS1_q <= linkTgl;
      tglS2_q <= tglS1_q;
      tglS3_q <= tglS2_q;
    end
  end

  assign cmdEv = tglS2_q ^ tglS3_q;

  // Command decode; command word is held steady by the link side
  assign limitSelectHi = linkCmd[CMD_A1_BIT];
  assign limitSelectLo = linkCmd[CMD_A0_BIT];
  assign isSys   = linkCmd[7:4] == OP_SYS;
  assign isWMask = isSys && linkCmd[3:1] == SYS_WMASK;
  assign isWFlag = isSys && linkCmd[3:1] == SYS_WFLAG;
  assign isWCfg  = linkCmd[7:4] == OP_CFG && !linkCmd[CMD_RD_BIT];
  assign isWLim  = linkCmd[7:4] == OP_LIM && !linkCmd[CMD_RD_BIT];
  assign isConv  = linkCmd[7:4] == OP_CONV
                   && (linkCmd[CMD_T_BIT] || linkCmd[CMD_P_BIT]);
  assign isKnown = isSys || linkCmd[7:4] == OP_CFG || linkCmd[7:4] == OP_LIM
                   || isConv || linkCmd[7:4] == OP_RADC || linkCmd[7:5] == OP_RREG;
  assign busy    = state_q != CONV_IDLE;

  // Busy refuses new conversions and config writes without acknowledge
  assign accept = cmdEv && isKnown && !(busy && (isWCfg || isConv));

  // Interrupt mask register
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      mask_q <= MASK_RST;
    else if (accept && isWMask)
      mask_q <= linkData[FLAG_W-1:0];
  end

  // Per-measurement configuration
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cfg_q[MEAS_T] <= CFG_RST;
      cfg_q[MEAS_P] <= CFG_RST;
    end
    else if (accept && isWCfg)
      cfg_q[limitSelectLo] <= linkData[CFG_W-1:0];
  end

  // Limit registers, 16 bits each
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      lim_q[0] <= LIM_LO_RST;
      lim_q[1] <= LIM_HI_RST;
      lim_q[2] <= LIM_LO_RST;
      lim_q[3] <= LIM_HI_RST;
    end
    else if (accept && isWLim)
      lim_q[{limitSelectHi, limitSelectLo}] <= linkData;
  end

  // Conversion sequencer: temperature, then pressure
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_q   <= CONV_IDLE;
      convCnt_q <= '0;
      wantP_q   <= 1'b0;
    end
    else
    begin
      unique case (state_q)
        CONV_IDLE:
          if (accept && isConv)
          begin
            wantP_q <= linkCmd[CMD_P_BIT];
            if (linkCmd[CMD_T_BIT])
            begin
              state_q   <= CONV_TEMP;
              convCnt_q <= convCycles(cfg_q[MEAS_T][CFG_OSR_LSB +: 3]);
            end
            else
            begin
              state_q   <= CONV_PRES;
              convCnt_q <= convCycles(cfg_q[MEAS_P][CFG_OSR_LSB +: 3]);
            end
          end
        CONV_TEMP:
          if (tDone && wantP_q)
          begin
            state_q   <= CONV_PRES;
            convCnt_q <= convCycles(cfg_q[MEAS_P][CFG_OSR_LSB +: 3]);
          end
          else if (tDone)
            state_q <= CONV_IDLE;
          else
            convCnt_q <= convCnt_q - CNT_W'(1);
        CONV_PRES:
          if (pDone)
            state_q <= CONV_IDLE;
          else
            convCnt_q <= convCnt_q - CNT_W'(1);
      endcase
    end
  end

  assign tDone   = state_q == CONV_TEMP && convCnt_q <= CNT_W'(1);
  assign pDone   = state_q == CONV_PRES && convCnt_q <= CNT_W'(1);
  assign convEnd = (tDone && !wantP_q) || pDone;

  // Result registers; all ones until the first conversion lands
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      resT_q <= RES_RST;
      resP_q <= RES_RST;
    end
    else
    begin
      if (tDone)
        resT_q <= adcTemp;
      if (pDone)
        resP_q <= adcPress;
    end
  end

  // Flag sources and host clears
  always_comb
  begin
    flagSet = '0;
    if (tDone)
      {flagSet[FLG_THIGH], flagSet[FLG_TLOW]} = limFlags(adcTemp, lim_q[0], lim_q[1]);
    if (pDone)
      {flagSet[FLG_PHIGH], flagSet[FLG_PLOW]} = limFlags(adcPress, lim_q[2], lim_q[3]);
    flagSet[FLG_DONE] = convEnd;
    flagClr = (accept && isWFlag) ? linkData[FLAG_W-1:0] : '0;
  end

  // Sticky flags: a new event wins over a clear in the same cycle
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      flags_q <= FLAG_RST;
    else
      flags_q <= (flags_q & ~flagClr) | flagSet;
  end

  // Interrupt pin from masked flags
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(flags_q & mask_q);
  end

  // Acknowledge stretch on the output after any accepted command
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      ackCnt_q <= '0;
    else if (accept)
      ackCnt_q <= ACK_W'(ACK_CYC);
    else if (ackCnt_q != '0)
      ackCnt_q <= ackCnt_q - ACK_W'(1);
  end

  // Coefficient store, filled by the memory loader
  always_ff @(posedge mclk)
  begin
    if (nvmWe)
      coefMem[nvmAddr] <= nvmData;
  end

  // Address is steady during a read frame, store is static then
  assign coefWord = coefMem[coefAddr];

  // Copies refresh only while no frame is open, so the link reads stable words
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      snapFlags_q   <= FLAG_RST;
      snapMask_q    <= MASK_RST;
      snapCfg_q[0]  <= CFG_RST;
      snapCfg_q[1]  <= CFG_RST;
      snapLim_q[0]  <= LIM_LO_RST;
      snapLim_q[1]  <= LIM_HI_RST;
      snapLim_q[2]  <= LIM_LO_RST;
      snapLim_q[3]  <= LIM_HI_RST;
      snapResT_q    <= RES_RST;
      snapResP_q    <= RES_RST;
    end
    else if (csbS2_q)
    begin
      snapFlags_q <= flags_q;
      snapMask_q  <= mask_q;
      snapCfg_q   <= cfg_q;
      snapLim_q   <= lim_q;
      snapResT_q  <= resT_q;
      snapResP_q  <= resP_q;
    end
  end

  // Data while reading, otherwise low when acknowledging or converting
  assign sdo = rdActive ? rdBit : !(busy || ackCnt_q != '0);
endmodule : spc_engine

// [testbench/spc_engine_sva.sv]
// Port checker of the sensor command engine
module spc_engine_sva #(
  parameter int CONV_BASE_CYCLES = 4
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic csbN,
  input wire logic sdo,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int BUSY_MAX = 2 * (CONV_BASE_CYCLES << 7) + 16;
  logic [3:0]  idleQ;
  logic [11:0] busyQ;

  // Cycles since the last frame, saturating
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) idleQ <= 4'hF;
    else if (!csbN) idleQ <= 4'h0;
    else if (idleQ != 4'hF) idleQ <= idleQ + 4'h1;

  // Length of a busy stretch outside frames
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) busyQ <= 12'h000;
    else if (csbN && !sdo) busyQ <= busyQ + 12'h001;
    else busyQ <= 12'h000;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_irq_reset: assert property (
    $rose(nrst) |-> !irq) else $error("irq high after reset");
  chk_sdo_reset: assert property (
    $rose(nrst) && csbN |-> sdo) else $error("sdo low after reset");
  chk_idle_held: assert property (
    csbN && sdo |=> sdo || !csbN) else $error("sdo fell outside a frame");
  chk_conv_bound: assert property (
    int'(busyQ) <= BUSY_MAX) else $error("busy level too long");
  chk_irq_clear: assert property (
    $fell(irq) |-> idleQ < 4'hA) else $error("irq fell without a frame");
  chk_irq_cause: assert property (
    $rose(irq) |-> idleQ < 4'hA || !$past(sdo) || !$past(sdo, 2))
    else $error("irq rose without a cause");
  chk_irq_quiet: assert property (
    csbN && sdo && $past(sdo) && $past(sdo, 2) && idleQ == 4'hF |-> $stable(irq))
    else $error("irq moved while idle");
  chk_frame_quiet: assert property (
    $fell(csbN) |-> $stable(sdo)) else $error("sdo moved at frame start");
endmodule : spc_engine_sva

// [testbench/spc_host_model.sv]
// Host serial master model for the sensor link
module spc_host_model (
  output logic scl,
  output logic csbN,
  output logic sdi,
  input  wire logic sdo
);
  timeunit 1ns;
  timeprecision 100ps;
  int   hp   = 15;
  logic cpol = 1'b0;

  // Idle line levels
  initial
  begin
    scl = 1'b0;
    csbN = 1'b1;
    sdi = 1'b0;
  end

  // One framed transfer, MSB first, write bits then read bits
  task automatic frame(input logic [7:0] cmd, input int nw, input logic [15:0] wd,
                       input int nr, output logic [47:0] rd);
    logic [23:0] tx;
    tx = {cmd, 16'(wd << (16 - nw))};
    rd = '0;
    scl = cpol;
    #hp csbN = 1'b0;
    #100;
    for (int i = 0; i < 8 + nw; i++)
    begin
      scl = 1'b0;
      sdi = tx[23 - i];
      #hp scl = 1'b1;
      #hp;
    end
    for (int i = 0; i < nr; i++)
    begin
      scl = 1'b0;
      #hp scl = 1'b1;
      rd = {rd[46:0], sdo};
      #hp;
    end
    scl = cpol; // Mode 3 stays high, no extra edge
    sdi = ~sdi;
    #hp;
    #300 csbN = 1'b1;
    #150;
  endtask : frame
endmodule : spc_host_model

// [testbench/testbench.sv]
// Self-checking bench of the sensor command engine
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import spc_pkg::*;
  logic        mclk = 1'b0;
  logic        nrst, scl, csbN, sdi, sdo, irq, nvmWe;
  logic [23:0] adcTemp, adcPress;
  logic [3:0]  nvmAddr;
  logic [15:0] nvmData;
  logic [47:0] rd;
  int          errors = 0;
  int          n_compared = 0;
  int          n;

  always #12.5 mclk = ~mclk;

  spc_engine #(.CONV_BASE_CYCLES(4)) spc_engine_inst (
    .mclk(mclk), .nrst(nrst), .scl(scl), .csbN(csbN), .sdi(sdi), .sdo(sdo),
    .irq(irq), .adcTemp(adcTemp), .adcPress(adcPress), .nvmWe(nvmWe),
    .nvmAddr(nvmAddr), .nvmData(nvmData));
  spc_host_model spc_host_model_inst (.scl(scl), .csbN(csbN), .sdi(sdi), .sdo(sdo));

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("Compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic xf(input logic [7:0] c, input int nw, input logic [15:0] w, input int nr);
    spc_host_model_inst.frame(c, nw, w, nr, rd);
  endtask : xf

  // Poll the busy level, bounded
  task automatic wait_idle();
    n = 0;
    while (sdo !== 1'b1)
    begin
      @(negedge mclk);
      n++;
      if (n > 2000)
      begin
        errors++;
        give_verdict();
      end
    end
  endtask : wait_idle

  task automatic t_reset();
    xf(8'h1E, 0, 16'h0, 8);
    chk(rd, 48'h0);
    xf(8'h5C, 0, 16'h0, 4);
    chk(rd, 48'hF);
    chk(48'(sdo), 48'h1);
    xf(8'h5C, 0, 16'h0, 34);
    chk(rd, 48'h3FFFFFFFC);
    for (int a = 0; a < 4; a++)
    begin
      xf(8'h38 | 8'(a << 1), 0, 16'h0, 16);
      chk(rd, a[0] ? 48'hFFFF : 48'h0);
    end
    $display("reset test done");
  endtask : t_reset

  task automatic t_coef();
    for (int a = 0; a < 16; a++)
    begin
      @(negedge mclk);
      nvmWe = 1'b1;
      nvmAddr = 4'(a);
      nvmData = 16'hC300 ^ 16'(a * 273);
    end
    @(negedge mclk);
    nvmWe = 1'b0;
    for (int a = 0; a < 16; a++)
    begin
      xf({3'h7, 4'(a), 1'b0}, 0, 16'h0, 16);
      chk(rd, 48'(16'hC300 ^ 16'(a * 273)));
    end
    $display("coefficient test done");
  endtask : t_coef

  task automatic t_cfg();
    logic [15:0] lim [4] = '{16'h0000, 16'h1000, 16'h8000, 16'hFFFF};
    spc_host_model_inst.cpol = 1'b1;
    xf(8'h20, 16, 16'h0544, 0);
    xf(8'h22, 16, 16'h02DE, 0);
    xf(8'h28, 0, 16'h0, 16);
    chk(rd, 48'h0544);
    xf(8'h2A, 0, 16'h0, 16);
    chk(rd, 48'h02DE);
    for (int a = 0; a < 4; a++)
      xf(8'h30 | 8'(a << 1), 16, lim[a], 0);
    for (int a = 0; a < 4; a++)
    begin
      xf(8'h38 | 8'(a << 1), 0, 16'h0, 16);
      chk(rd, 48'(lim[a]));
    end
    spc_host_model_inst.cpol = 1'b0;
    $display("config test done");
  endtask : t_cfg

  task automatic t_conv();
    adcTemp = 24'h0800AA;
    xf(8'h48, 0, 16'h0, 0);
    chk(48'(sdo), 48'h0);
    wait_idle();
    chk(48'(n >= 44 && n <= 53), 48'h1);
    adcPress = 24'hABCDEF;
    xf(8'h44, 0, 16'h0, 0);
    wait_idle();
    chk(48'(n >= 236 && n <= 245), 48'h1);
    xf(8'h5C, 0, 16'h0, 40);
    chk(rd, {8'h0, 16'h0800, 24'hABCDEF});
    $display("conversion test done");
  endtask : t_conv

  task automatic t_seq();
    adcTemp = 24'h200000;
    adcPress = 24'h123456;
    xf(8'h4C, 0, 16'h0, 0);
    repeat (60) @(negedge mclk);
    xf(8'h5C, 0, 16'h0, 40);
    chk(rd, {8'h0, 16'h2000, 24'hABCDEF});
    xf(8'h20, 16, 16'h0000, 0);
    wait_idle();
    xf(8'h28, 0, 16'h0, 16);
    chk(rd, 48'h0544);
    xf(8'h5C, 0, 16'h0, 40);
    chk(rd, {8'h0, 16'h2000, 24'h123456});
    $display("sequence test done");
  endtask : t_seq

  task automatic t_flags();
    xf(8'h1E, 0, 16'h0, 8);
    chk(rd, 48'h31);
    xf(8'h1E, 0, 16'h0, 8);
    chk(rd, 48'h31);
    chk(48'(irq), 48'h0);
    xf(8'h18, 8, 16'h0010, 0);
    chk(48'(irq), 48'h1);
    xf(8'h1A, 0, 16'h0, 8);
    chk(rd, 48'h10);
    xf(8'h1C, 8, 16'h0001, 0);
    xf(8'h1E, 0, 16'h0, 8);
    chk(rd, 48'h30);
    chk(48'(irq), 48'h1);
    xf(8'h1C, 8, 16'h0010, 0);
    chk(48'(irq), 48'h0);
    xf(8'h1E, 0, 16'h0, 8);
    chk(rd, 48'h20);
    $display("flag test done");
  endtask : t_flags

  // Main sequence
  initial
  begin
    nrst = 1'b0;
    adcTemp = 24'h0;
    adcPress = 24'h0;
    nvmWe = 1'b0;
    nvmAddr = 4'h0;
    nvmData = 16'h0;
    repeat (12) @(negedge mclk);
    nrst = 1'b1;
    repeat (3) @(negedge mclk);
    t_reset();
    t_coef();
    t_cfg();
    t_conv();
    t_seq();
    t_flags();
    give_verdict();
  end
endmodule : testbench

bind spc_engine spc_engine_sva #(.CONV_BASE_CYCLES(CONV_BASE_CYCLES)) spc_engine_sva_inst (
  .mclk(mclk), .nrst(nrst), .csbN(csbN), .sdo(sdo), .irq(irq));
